// ---- pkg/qdcf_pkg.sv ----
// Purpose: Shared constants, types and ring arithmetic for the queue doorbell command flow.
// Assumes: Queue slots are indexed from zero and wrap after the last slot.
// Notes:   Queue 0 is the admin queue pair; queues 1 to NQ-1 are I/O queues.
`default_nettype none

package qdcf_pkg;

	localparam int unsigned NQ    = 4;
	localparam int unsigned QNW   = 2;
	localparam int unsigned IDXW  = 8;
	localparam int unsigned TAGW  = 16;
	localparam int unsigned STATW = 15;
	localparam int unsigned OPCW  = 8;

	typedef logic [IDXW-1:0] qdcf_idx_t;
	typedef logic [QNW-1:0]  qdcf_qn_t;

	localparam qdcf_qn_t  ADMIN_Q             = 2'h0;
	localparam qdcf_idx_t MAX_QUEUE_DEPTH_CAP = 8'hff;
	localparam qdcf_idx_t RST_IDX             = 8'h00;
	localparam logic      RST_PHASE           = 1'b1;

	// Paired operation marker encodings.
	localparam logic [1:0] PAIRED_OP_MARKER_NONE   = 2'h0;
	localparam logic [1:0] PAIRED_OP_MARKER_FIRST  = 2'h1;
	localparam logic [1:0] PAIRED_OP_MARKER_SECOND = 2'h2;

	// Queue priority classes, lower value wins.
	localparam logic [1:0] PRIO_URGENT = 2'h0;
	localparam logic [1:0] PRIO_HIGH   = 2'h1;
	localparam logic [1:0] PRIO_MEDIUM = 2'h2;
	localparam logic [1:0] PRIO_LOW    = 2'h3;

	// Completion entry field positions.
	localparam int unsigned DW2_HEAD_LSB  = 0;
	localparam int unsigned DW2_SOURCE_QUEUE_NUMBER_LSB  = 16;
	localparam int unsigned DW3_TAG_LSB   = 0;
	localparam int unsigned DW3_PHASE_BIT = 16;
	localparam int unsigned DW3_STAT_LSB  = 17;

	typedef enum logic [1:0]
	{
		FS_IDLE  = 2'b00,
		FS_REQ   = 2'b01,
		FS_WAIT  = 2'b11,
		FS_ISSUE = 2'b10
	} qdcf_fetch_e;

	function automatic qdcf_idx_t ring_next(input qdcf_idx_t p, input qdcf_idx_t dm1);
		ring_next = (p == dm1) ? RST_IDX : qdcf_idx_t'(p + 8'h01);
	endfunction : ring_next

	// Entries from a up to b in a ring of dm1+1 slots.
	function automatic qdcf_idx_t ring_dist(input qdcf_idx_t a, input qdcf_idx_t b,
		input qdcf_idx_t dm1);
		logic [IDXW:0] s;
		s = (b >= a) ? ({1'b0, b} - {1'b0, a}) : ({1'b0, b} + {1'b0, dm1} + 9'h001 - {1'b0, a});
		ring_dist = s[IDXW-1:0];
	endfunction : ring_dist

endpackage : qdcf_pkg

`default_nettype wire

// ---- src/qdcf_arbiter.sv ----
// Purpose: Picks the next submission queue to fetch from by class, then round robin.
// Assumes: Requests and classes come from logic on clk_sys.
// Notes:   Strict class order can starve low classes; round robin is only within a class.
`timescale 1ns/10ps
`default_nettype none

module qdcf_arbiter
	import qdcf_pkg::*;
(
	// Clock and reset.
	input  wire logic                       clk_sys,
	input  wire logic                       rst_n,
	// Requests.
	input  wire logic [qdcf_pkg::NQ-1:0]    req,
	input  wire logic [qdcf_pkg::NQ-1:0][1:0] prio,
	input  wire logic                       lock,
	input  wire qdcf_pkg::qdcf_qn_t         lock_num,
	input  wire logic                       advance,
	// Grant.
	output logic                            grant_valid,
	output qdcf_pkg::qdcf_qn_t              grant_idx
);

	qdcf_qn_t last_q;

	always_comb
	begin
		logic [2:0] best;
		logic [2:0] cls;
		qdcf_qn_t   i;
		best        = 3'h4;
		cls         = 3'h4;
		i           = ADMIN_Q;
		grant_valid = 1'b0;
		grant_idx   = ADMIN_Q;
		for (int n = 0; n < NQ; n++)
		begin
			cls = (n == 0) ? {1'b0, PRIO_URGENT} : {1'b0, prio[n]};
			if (req[n] && cls < best)
				best = cls;
		end
		if (lock)
		begin
			grant_valid = req[lock_num];
			grant_idx   = lock_num;
		end
		else
		begin
			for (int off = 1; off <= NQ; off++)
			begin
				i   = qdcf_qn_t'(last_q + off[QNW-1:0]);
				cls = (i == ADMIN_Q) ? {1'b0, PRIO_URGENT} : {1'b0, prio[i]};
				if (!grant_valid && req[i] && cls == best)
				begin
					grant_valid = 1'b1;
					grant_idx   = i;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			last_q <= ADMIN_Q;
		else if (advance)
			last_q <= grant_idx;
	end

endmodule : qdcf_arbiter

`default_nettype wire

// ---- src/qdcf_queue_flow.sv ----
// Purpose: Doorbells, command fetch, issue and completion posting for paired queues.
// Assumes: Fetch, execution and posting partners share clk_sys and use valid/ready.
// Notes:   One fetch is in flight at a time; the executor may finish commands in any order.
`timescale 1ns/10ps
`default_nettype none

module qdcf_queue_flow
	import qdcf_pkg::*;
(
	// Clock and reset.
	input  wire logic                       clk_sys,
	input  wire logic                       rst_n,
	// Controller control and status.
	input  wire logic                       controller_enable_bit,
	output logic                            controller_ready_flag,
	input  wire qdcf_pkg::qdcf_idx_t        admin_sq_depth_m1,
	input  wire qdcf_pkg::qdcf_idx_t        admin_cq_depth_m1,
	input  wire logic                       multi_vector_mode,
	input  wire logic [qdcf_pkg::NQ-1:0]    cq_irq_enable,
	// Queue create and delete.
	input  wire logic                       q_cfg_wr,
	input  wire logic                       q_cfg_is_cq,
	input  wire logic                       q_cfg_live,
	input  wire qdcf_pkg::qdcf_qn_t         queue_number,
	input  wire qdcf_pkg::qdcf_idx_t        queue_depth_minus_one,
	input  wire qdcf_pkg::qdcf_qn_t         target_completion_queue,
	input  wire logic [1:0]                 queue_priority_class,
	output logic                            q_cfg_error,
	// Doorbells.
	input  wire logic                       submission_tail_doorbell,
	input  wire logic                       completion_head_doorbell,
	input  wire qdcf_pkg::qdcf_qn_t         db_queue,
	input  wire qdcf_pkg::qdcf_idx_t        db_value,
	output logic                            db_error,
	output qdcf_pkg::qdcf_idx_t             db_new_count,
	output logic                            db_new_valid,
	// Command fetch from host memory.
	output logic                            fetch_req_valid,
	input  wire logic                       fetch_req_ready,
	output qdcf_pkg::qdcf_qn_t              fetch_queue,
	output qdcf_pkg::qdcf_idx_t             fetch_slot,
	input  wire logic                       fetch_rsp_valid,
	input  wire logic [qdcf_pkg::OPCW-1:0]  operation_code,
	input  wire logic [1:0]                 paired_op_marker,
	input  wire logic [qdcf_pkg::TAGW-1:0]  command_tag,
	// Command issue to the executor.
	output logic                            cmd_valid,
	input  wire logic                       cmd_ready,
	output qdcf_pkg::qdcf_qn_t              cmd_queue,
	output logic [qdcf_pkg::OPCW-1:0]       cmd_opcode,
	output logic [1:0]                      cmd_pair,
	output logic [qdcf_pkg::TAGW-1:0]       cmd_tag,
	// Command done from the executor.
	input  wire logic                       done_valid,
	output logic                            done_ready,
	input  wire qdcf_pkg::qdcf_qn_t         done_queue,
	input  wire logic [qdcf_pkg::TAGW-1:0]  done_tag,
	input  wire logic [qdcf_pkg::STATW-1:0] completion_status_field,
	// Completion entry write to host memory.
	output logic                            post_valid,
	input  wire logic                       post_ready,
	output qdcf_pkg::qdcf_qn_t              post_cq,
	output qdcf_pkg::qdcf_idx_t             post_slot,
	output logic [31:0]                     post_dw2,
	output logic [31:0]                     post_dw3,
	// Interrupt message.
	output logic                            irq_msg_valid,
	output qdcf_pkg::qdcf_qn_t              irq_vector,
	output logic [qdcf_pkg::NQ-1:0]         irq_pending
);

	logic [NQ-1:0]           sq_live_q;
	logic [NQ-1:0]           cq_live_q;
	logic [NQ-1:0][IDXW-1:0] sq_dm1_q;
	logic [NQ-1:0][IDXW-1:0] cq_dm1_q;
	logic [NQ-1:0][QNW-1:0]  sq_cq_q;
	logic [NQ-1:0][1:0]      sq_prio_q;
	logic [NQ-1:0][IDXW-1:0] sq_tail_q;
	logic [NQ-1:0][IDXW-1:0] sq_head_q;
	logic [NQ-1:0][IDXW-1:0] cq_tail_q;
	logic [NQ-1:0][IDXW-1:0] cq_head_q;
	logic [NQ-1:0]           cq_phase_q;
	logic [NQ-1:0]           sq_req;
	qdcf_fetch_e             fs_q;
	logic                    lock_q;
	qdcf_qn_t                lock_num_q;
	logic                    grant_valid;
	qdcf_qn_t                grant_idx;
	logic                    fetch_go;
	logic                    fetch_take;
	logic                    done_take;
	logic                    post_take;
	logic                    sq_db_ok;
	logic                    cq_db_ok;
	logic                    cfg_ok;
	qdcf_qn_t                done_cq;
	logic                    en;

	assign en         = controller_enable_bit;
	assign fetch_go   = en && fs_q == FS_IDLE && grant_valid;
	assign fetch_take = fs_q == FS_REQ && fetch_req_ready;
	assign post_take  = post_valid && post_ready;
	assign done_cq    = sq_cq_q[done_queue];
	assign sq_db_ok   = sq_live_q[db_queue] && db_value <= sq_dm1_q[db_queue];
	assign cq_db_ok   = cq_live_q[db_queue] && db_value <= cq_dm1_q[db_queue];
	assign cfg_ok     = queue_number != ADMIN_Q && queue_depth_minus_one <= MAX_QUEUE_DEPTH_CAP
		&& (q_cfg_is_cq || !q_cfg_live || cq_live_q[target_completion_queue]);
	assign fetch_req_valid = fs_q == FS_REQ;
	assign cmd_valid       = fs_q == FS_ISSUE;

	// A completion is taken only when its queue has a free slot and the output stage is empty.
	assign done_ready = en && !post_valid && cq_live_q[done_cq]
		&& ring_next(cq_tail_q[done_cq], cq_dm1_q[done_cq]) != cq_head_q[done_cq];
	assign done_take  = done_valid && done_ready;

	always_comb
	begin
		for (int n = 0; n < NQ; n++)
			sq_req[n] = sq_live_q[n] && sq_head_q[n] != sq_tail_q[n];
	end

	qdcf_arbiter u_arb
	(
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.req         (sq_req),
		.prio        (sq_prio_q),
		.lock        (lock_q),
		.lock_num    (lock_num_q),
		.advance     (fetch_go),
		.grant_valid (grant_valid),
		.grant_idx   (grant_idx)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Queue configuration.

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sq_live_q <= '0;
			cq_live_q <= '0;
			sq_dm1_q  <= '0;
			cq_dm1_q  <= '0;
			sq_cq_q   <= '0;
			sq_prio_q <= '0;
		end
		else if (!en)
		begin
			sq_live_q <= '0;
			cq_live_q <= '0;
		end
		else
		begin
			sq_live_q[ADMIN_Q] <= 1'b1;
			cq_live_q[ADMIN_Q] <= 1'b1;
			sq_dm1_q[ADMIN_Q]  <= admin_sq_depth_m1;
			cq_dm1_q[ADMIN_Q]  <= admin_cq_depth_m1;
			sq_cq_q[ADMIN_Q]   <= ADMIN_Q;
			sq_prio_q[ADMIN_Q] <= PRIO_URGENT;
			if (q_cfg_wr && cfg_ok && q_cfg_is_cq)
			begin
				cq_live_q[queue_number] <= q_cfg_live;
				cq_dm1_q[queue_number]  <= queue_depth_minus_one;
			end
			else if (q_cfg_wr && cfg_ok)
			begin
				sq_live_q[queue_number] <= q_cfg_live;
				sq_dm1_q[queue_number]  <= queue_depth_minus_one;
				sq_cq_q[queue_number]   <= target_completion_queue;
				sq_prio_q[queue_number] <= queue_priority_class;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			q_cfg_error <= 1'b0;
		else
			q_cfg_error <= q_cfg_wr && !cfg_ok;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Submission side: tail doorbell and fetch pointer.

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sq_tail_q    <= '0;
			db_new_valid <= 1'b0;
			db_new_count <= RST_IDX;
			db_error     <= 1'b0;
		end
		else
		begin
			db_new_valid <= 1'b0;
			db_error     <= (submission_tail_doorbell && !sq_db_ok)
				|| (completion_head_doorbell && !cq_db_ok);
			for (int n = 0; n < NQ; n++)
				if (!en || (q_cfg_wr && cfg_ok && !q_cfg_is_cq && queue_number == n))
					sq_tail_q[n] <= RST_IDX;
			if (en && submission_tail_doorbell && sq_db_ok)
			begin
				sq_tail_q[db_queue] <= db_value;
				db_new_valid        <= 1'b1;
				db_new_count        <= ring_dist(sq_tail_q[db_queue], db_value,
					sq_dm1_q[db_queue]);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			sq_head_q <= '0;
		else
		begin
			for (int n = 0; n < NQ; n++)
				if (!en || (q_cfg_wr && cfg_ok && !q_cfg_is_cq && queue_number == n))
					sq_head_q[n] <= RST_IDX;
				else if (fetch_take && fetch_queue == n)
					sq_head_q[n] <= ring_next(sq_head_q[n], sq_dm1_q[n]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fetch and issue sequence.

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fs_q        <= FS_IDLE;
			fetch_queue <= ADMIN_Q;
			fetch_slot  <= RST_IDX;
		end
		else if (!en)
			fs_q <= FS_IDLE;
		else
		begin
			unique case (fs_q)
				FS_IDLE:
					if (fetch_go)
					begin
						fetch_queue <= grant_idx;
						fetch_slot  <= sq_head_q[grant_idx];
						fs_q        <= FS_REQ;
					end
				FS_REQ:
					if (fetch_req_ready)
						fs_q <= FS_WAIT;
				FS_WAIT:
					if (fetch_rsp_valid)
						fs_q <= FS_ISSUE;
				FS_ISSUE:
					if (cmd_ready)
						fs_q <= FS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_queue  <= ADMIN_Q;
			cmd_opcode <= '0;
			cmd_pair   <= PAIRED_OP_MARKER_NONE;
			cmd_tag    <= '0;
		end
		else if (fs_q == FS_WAIT && fetch_rsp_valid)
		begin
			cmd_queue  <= fetch_queue;
			cmd_opcode <= operation_code;
			cmd_pair   <= paired_op_marker;
			cmd_tag    <= command_tag;
		end
	end

	// The arbiter is held on a queue after a first-of-pair so the second follows it directly.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lock_q     <= 1'b0;
			lock_num_q <= ADMIN_Q;
		end
		else if (!en)
			lock_q <= 1'b0;
		else if (fs_q == FS_ISSUE && cmd_ready)
		begin
			lock_q     <= cmd_pair == PAIRED_OP_MARKER_FIRST;
			lock_num_q <= cmd_queue;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Completion side.

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cq_tail_q  <= '0;
			cq_phase_q <= {NQ{RST_PHASE}};
		end
		else
		begin
			for (int n = 0; n < NQ; n++)
				if (!en || (q_cfg_wr && cfg_ok && q_cfg_is_cq && queue_number == n))
				begin
					cq_tail_q[n]  <= RST_IDX;
					cq_phase_q[n] <= RST_PHASE;
				end
				else if (done_take && done_cq == n)
				begin
					cq_tail_q[n] <= ring_next(cq_tail_q[n], cq_dm1_q[n]);
					if (cq_tail_q[n] == cq_dm1_q[n])
						cq_phase_q[n] <= !cq_phase_q[n];
				end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cq_head_q <= '0;
		else
		begin
			for (int n = 0; n < NQ; n++)
				if (!en || (q_cfg_wr && cfg_ok && q_cfg_is_cq && queue_number == n))
					cq_head_q[n] <= RST_IDX;
				else if (completion_head_doorbell && cq_db_ok && db_queue == n)
					cq_head_q[n] <= db_value;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			post_valid <= 1'b0;
			post_cq    <= ADMIN_Q;
			post_slot  <= RST_IDX;
			post_dw2   <= 32'h0000_0000;
			post_dw3   <= 32'h0000_0000;
		end
		else if (!en)
			post_valid <= 1'b0;
		else if (done_take)
		begin
			post_valid <= 1'b1;
			post_cq    <= done_cq;
			post_slot  <= cq_tail_q[done_cq];
			post_dw2   <= 32'h0000_0000;
			post_dw2[DW2_SOURCE_QUEUE_NUMBER_LSB +: QNW]  <= done_queue;
			post_dw2[DW2_HEAD_LSB +: IDXW] <= sq_head_q[done_queue];
			post_dw3[DW3_TAG_LSB +: TAGW]   <= done_tag;
			post_dw3[DW3_PHASE_BIT]         <= cq_phase_q[done_cq];
			post_dw3[DW3_STAT_LSB +: STATW] <= completion_status_field;
		end
		else if (post_take)
			post_valid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt signalling and ready flag.

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_pending   <= '0;
			irq_msg_valid <= 1'b0;
			irq_vector    <= ADMIN_Q;
		end
		else
		begin
			irq_msg_valid <= 1'b0;
			for (int n = 0; n < NQ; n++)
				if (!en)
					irq_pending[n] <= 1'b0;
				else if (post_take && post_cq == n && cq_irq_enable[n])
					irq_pending[n] <= 1'b1;
				else if (completion_head_doorbell && cq_db_ok && db_queue == n)
					irq_pending[n] <= 1'b0;
			if (en && post_take && cq_irq_enable[post_cq])
			begin
				irq_msg_valid <= 1'b1;
				irq_vector    <= multi_vector_mode ? post_cq : ADMIN_Q;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			controller_ready_flag <= 1'b0;
		else if (en)
			controller_ready_flag <= 1'b1;
		else if (fs_q == FS_IDLE && !post_valid)
			controller_ready_flag <= 1'b0;
	end

endmodule : qdcf_queue_flow

`default_nettype wire

// ---- sim/qdcf_chk.sv ----
// Purpose: Port checks for the queue doorbell command flow.
// Assumes: One clock; rst_n is asynchronous and active low.
// Notes:   Bound by name to every instance of the top module.
`timescale 1ns/10ps
`default_nettype none

module qdcf_chk
	import qdcf_pkg::*;
(
	// Control.
	input wire logic	clk_sys,
	input wire logic	rst_n,
	input wire logic	controller_enable_bit,
	input wire logic	controller_ready_flag,
	input wire logic	multi_vector_mode,
	input wire logic [qdcf_pkg::NQ-1:0]	cq_irq_enable,
	// Doorbells.
	input wire logic	submission_tail_doorbell,
	input wire logic	completion_head_doorbell,
	input wire qdcf_pkg::qdcf_qn_t	db_queue,
	input wire logic	db_error,
	input wire logic	db_new_valid,
	// Fetch and issue.
	input wire logic	fetch_req_valid,
	input wire logic	fetch_req_ready,
	input wire qdcf_pkg::qdcf_idx_t	fetch_slot,
	input wire logic	cmd_valid,
	input wire logic	cmd_ready,
	input wire logic [qdcf_pkg::TAGW-1:0]	cmd_tag,
	// Done, post and interrupt.
	input wire logic	done_valid,
	input wire logic	done_ready,
	input wire qdcf_pkg::qdcf_qn_t	done_queue,
	input wire logic [qdcf_pkg::TAGW-1:0]	done_tag,
	input wire logic [qdcf_pkg::STATW-1:0]	completion_status_field,
	input wire logic	post_valid,
	input wire logic	post_ready,
	input wire qdcf_pkg::qdcf_qn_t	post_cq,
	input wire logic [31:0]	post_dw3,
	input wire logic [31:0]	post_dw2,
	input wire logic	irq_msg_valid,
	input wire qdcf_pkg::qdcf_qn_t	irq_vector,
	input wire logic [qdcf_pkg::NQ-1:0]	irq_pending
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// The enable is caught on the handshake edge, since software may change it later.
	logic	irq_want_q;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irq_want_q <= 1'b0;
		else
			irq_want_q <= cq_irq_enable[post_cq];
	end

	sequence s_done_taken;
		done_valid && done_ready && controller_enable_bit;
	endsequence

	sequence s_posted;
		post_valid && post_ready && controller_enable_bit;
	endsequence

	tail_count_a: assert property (
		db_new_valid |-> $past(submission_tail_doorbell))
		else $error("new count without tail write");
	fetch_hold_a: assert property (
		fetch_req_valid && !fetch_req_ready && controller_enable_bit
		|=> fetch_req_valid && $stable(fetch_slot))
		else $error("fetch request dropped");
	issue_hold_a: assert property (
		cmd_valid && !cmd_ready && controller_enable_bit |=> cmd_valid && $stable(cmd_tag))
		else $error("issued command dropped");
	entry_fields_a: assert property (
		s_done_taken |=> post_valid && post_dw2[17:16] == $past(done_queue)
		&& post_dw3[15:0] == $past(done_tag)
		&& post_dw3[31:17] == $past(completion_status_field))
		else $error("entry fields wrong");
	post_hold_a: assert property (
		post_valid && !post_ready && controller_enable_bit
		|=> post_valid && $stable(post_dw3) && $stable(post_cq))
		else $error("completion write dropped");
	irq_vector_a: assert property (
		irq_msg_valid |-> irq_vector == ($past(multi_vector_mode) ? $past(post_cq) : ADMIN_Q))
		else $error("wrong vector");
	irq_gate_a: assert property (
		s_posted |=> irq_msg_valid == irq_want_q)
		else $error("interrupt not per enable");
	irq_clear_a: assert property (
		completion_head_doorbell && controller_enable_bit && !(post_valid && post_ready)
		|=> db_error || !irq_pending[$past(db_queue)])
		else $error("head write left interrupt pending");
	ready_rise_a: assert property (
		$rose(controller_enable_bit) |=> controller_ready_flag)
		else $error("ready late");
	ready_fall_a: assert property (
		$fell(controller_enable_bit) |-> ##[1:4] !controller_ready_flag)
		else $error("ready stuck");
	quiet_off_a: assert property (
		!controller_enable_bit |=> !fetch_req_valid && !cmd_valid && !post_valid)
		else $error("activity while disabled");

endmodule : qdcf_chk

bind qdcf_queue_flow qdcf_chk i_chk (.*);

`default_nettype wire

// ---- sim/qdcf_host_model.sv ----
// Purpose: Host memory side: serves command fetches and takes completion writes.
// Assumes: Shares clk_sys with the block.
// Notes:   Slow mode answers only one cycle in four.
`timescale 1ns/10ps
`default_nettype none

module qdcf_host_model
	import qdcf_pkg::*;
(
	// Clock, reset and behaviour.
	input wire logic	clk_sys,
	input wire logic	rst_n,
	input wire logic	slow,
	input wire qdcf_pkg::qdcf_idx_t	pair_slot,
	// Fetch.
	input wire logic	fetch_req_valid,
	output logic	fetch_req_ready,
	input wire qdcf_pkg::qdcf_qn_t	fetch_queue,
	input wire qdcf_pkg::qdcf_idx_t	fetch_slot,
	output logic	fetch_rsp_valid,
	output logic [qdcf_pkg::OPCW-1:0]	operation_code,
	output logic [1:0]	paired_op_marker,
	output logic [qdcf_pkg::TAGW-1:0]	command_tag,
	// Completion write.
	input wire logic	post_valid,
	output logic	post_ready
);
	logic [1:0]	wait_q;
	wire	go = !slow || wait_q == 2'h3;
	wire	hs = fetch_req_valid && fetch_req_ready;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_q <= 2'h0;
			fetch_req_ready <= 1'b0;
			fetch_rsp_valid <= 1'b0;
			post_ready <= 1'b0;
		end
		else
		begin
			wait_q <= wait_q + 2'h1;
			fetch_req_ready <= fetch_req_valid && !fetch_req_ready && go;
			fetch_rsp_valid <= hs;
			post_ready <= post_valid && !post_ready && go;
		end
	end

	// Outside a response the fields flip, so stale data is never mistaken for a reply.
	// Page entries and the metadata pointer stay in host memory; the block never reads them.
	always_ff @(posedge clk_sys)
	begin
		if (hs)
		begin
			operation_code <= 8'h02;
			paired_op_marker <= fetch_slot == pair_slot ? PAIRED_OP_MARKER_FIRST
				: fetch_slot == pair_slot + 8'h01 ? PAIRED_OP_MARKER_SECOND : PAIRED_OP_MARKER_NONE;
			command_tag <= {6'h00, fetch_queue, fetch_slot};
		end
		else
		begin
			operation_code <= ~operation_code;
			paired_op_marker <= ~paired_op_marker;
			command_tag <= ~command_tag;
		end
	end

endmodule : qdcf_host_model

`default_nettype wire

// ---- sim/qdcf_queue_flow_bench.sv ----
// Purpose: Self-checking bench for the queue doorbell command flow.
// Assumes: Inputs change at the falling edge of clk_sys.
// Notes:   The bench is the executor and finishes commands in reverse order.
`timescale 1ns/10ps
`default_nettype none

module qdcf_queue_flow_bench;
	import qdcf_pkg::*;

	logic	clk_sys, controller_ready_flag, q_cfg_error, db_error, db_new_valid;
	logic	fetch_req_valid, fetch_req_ready, fetch_rsp_valid, cmd_valid, done_ready;
	logic	post_valid, post_ready, irq_msg_valid, rst_n = 1'b0, slow = 1'b0;
	logic	controller_enable_bit = 1'b0, multi_vector_mode = 1'b1, cmd_ready = 1'b0;
	logic	q_cfg_wr = 1'b0, q_cfg_is_cq = 1'b0, q_cfg_live = 1'b0, done_valid = 1'b0;
	logic	submission_tail_doorbell = 1'b0, completion_head_doorbell = 1'b0;
	qdcf_qn_t	fetch_queue, cmd_queue, post_cq, irq_vector, queue_number = 2'h0;
	qdcf_qn_t	target_completion_queue = 2'h0, db_queue = 2'h0, done_queue = 2'h0;
	qdcf_idx_t	db_new_count, fetch_slot, post_slot, db_value = 8'h00, pair_slot = 8'h00;
	qdcf_idx_t	admin_sq_depth_m1 = 8'h03, admin_cq_depth_m1 = 8'h03;
	qdcf_idx_t	queue_depth_minus_one = 8'h03;
	logic [1:0]	paired_op_marker, cmd_pair, queue_priority_class = PRIO_MEDIUM;
	logic [7:0]	operation_code, cmd_opcode;
	logic [15:0]	command_tag, cmd_tag, done_tag = 16'h0000;
	logic [14:0]	completion_status_field = 15'h0000;
	logic [31:0]	post_dw2, post_dw3;
	logic [3:0]	irq_pending, cq_irq_enable = 4'h0;
	logic [15:0]	issued[$];
	qdcf_idx_t	next_slot [4] = '{default: 8'h00};
	int	failures = 0, samples_checked = 0, cycles = 0;
	localparam logic [15:0] ORDER [5] = '{16'h0100, 16'h0101, 16'h0000, 16'h0001, 16'h0102};

	qdcf_queue_flow i_dut (.*);
	qdcf_host_model i_host (.*);

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cmd_valid && cmd_ready)
		begin
			issued.push_back(cmd_tag);
			chk({cmd_queue, cmd_opcode}, {cmd_tag[9:8], 8'h02});
			chk(cmd_pair, (pair_slot == 8'h00 && cmd_tag[7:1] == 7'h00)
				? {cmd_tag[0], !cmd_tag[0]} : PAIRED_OP_MARKER_NONE);
		end
		if (cycles == 4000)
		begin
			failures++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick

	// SQ n always targets CQ n; the refusal flag answers one clock later.
	task automatic cfg(input logic cq, input qdcf_qn_t q, input logic live, input logic err);
		q_cfg_wr = 1'b1;
		q_cfg_is_cq = cq;
		q_cfg_live = live;
		queue_number = q;
		target_completion_queue = q;
		tick(1);
		q_cfg_wr = 1'b0;
		chk(q_cfg_error, err);
		tick(1);
	endtask : cfg

	task automatic ring(input logic tl, input qdcf_qn_t q, input qdcf_idx_t v,
		input logic err, input qdcf_idx_t n);
		submission_tail_doorbell = tl;
		completion_head_doorbell = !tl;
		db_queue = q;
		db_value = v;
		tick(1);
		submission_tail_doorbell = 1'b0;
		completion_head_doorbell = 1'b0;
		chk(db_error, err);
		if (tl && !err)
			chk({db_new_valid, db_new_count}, {1'b1, n});
		tick(1);
	endtask : ring

	task automatic fin(input logic [15:0] t, input qdcf_idx_t hd);
		int k;
		done_valid = 1'b1;
		done_queue = t[9:8];
		done_tag = t;
		completion_status_field = 15'h4321 ^ 15'(t);
		k = 0;
		do @(posedge clk_sys); while (!done_ready && ++k < 50);
		@(negedge clk_sys);
		done_valid = 1'b0;
		k = 0;
		do @(posedge clk_sys); while (!(post_valid && post_ready) && ++k < 50);
		chk(post_dw2, {14'h0000, t[9:8], 8'h00, hd});
		chk(post_dw3, {15'h4321 ^ 15'(t), 1'b1, t});
		chk(post_cq, t[9:8]);
		chk(post_slot, next_slot[t[9:8]]);
		next_slot[t[9:8]]++;
		@(negedge clk_sys);
	endtask : fin

	////////////////////////////////////////////////////////////////
	initial
	begin
		tick(16);
		rst_n = 1'b1;
		tick(1);
		chk(controller_ready_flag, 1'b0);
		controller_enable_bit = 1'b1;
		tick(2);
		chk(controller_ready_flag, 1'b1);
		cfg(1'b0, 2'h2, 1'b1, 1'b1);
		cfg(1'b1, 2'h0, 1'b1, 1'b1);
		cfg(1'b1, 2'h1, 1'b1, 1'b0);
		cfg(1'b0, 2'h1, 1'b1, 1'b0);
		ring(1'b1, 2'h1, 8'h03, 1'b0, 8'h03);
		ring(1'b1, 2'h0, 8'h02, 1'b0, 8'h02);
		ring(1'b1, 2'h1, 8'h04, 1'b1, 8'h00);
		tick(10);
		cmd_ready = 1'b1;
		for (int k = 0; k < 200 && issued.size() < 5; k++)
			tick(1);
		foreach (ORDER[i])
			chk(issued[i], ORDER[i]);
		pair_slot = 8'h80;
		slow = 1'b1;
		cq_irq_enable = 4'h2;
		for (int i = 4; i >= 0; i--)
		begin
			multi_vector_mode = i[0];
			fin(ORDER[i], ORDER[i][8] ? 8'h03 : 8'h02);
		end
		chk(irq_pending, 4'h2);
		ring(1'b0, 2'h1, 8'h03, 1'b0, 8'h00);
		chk(irq_pending, 4'h0);
		ring(1'b1, 2'h1, 8'h01, 1'b0, 8'h02);
		for (int k = 0; k < 200 && issued.size() < 7; k++)
			tick(1);
		chk(issued[5], 16'h0103);
		chk(issued[6], 16'h0100);
		cfg(1'b0, 2'h1, 1'b0, 1'b0);
		ring(1'b1, 2'h1, 8'h02, 1'b1, 8'h00);
		controller_enable_bit = 1'b0;
		tick(4);
		chk(controller_ready_flag, 1'b0);
		controller_enable_bit = 1'b1;
		tick(2);
		chk(controller_ready_flag, 1'b1);
		ring(1'b0, 2'h1, 8'h00, 1'b1, 8'h00);
		end_sim();
	end

endmodule : qdcf_queue_flow_bench

`default_nettype wire
